/* common/lpm_pkg.sv */
// shared constants and types of the low-power mode controller
package lpm_pkg;

	// register byte offsets
	localparam logic [7:0] REG_MODE   = 8'h00;
	localparam logic [7:0] REG_STACK  = 8'h04;
	localparam logic [7:0] REG_CFG    = 8'h08;
	localparam logic [7:0] REG_IRQ_EN = 8'h0c;
	localparam logic [7:0] REG_STATUS = 8'h10;
	localparam logic [7:0] REG_PEND   = 8'h14;

	// field positions inside the status word byte
	localparam int BIT_IRQ_ON = 3;
	localparam int BIT_CPUHLT = 4;
	localparam int BIT_LFOFF  = 5;
	localparam int BIT_LOOPOF = 6;
	localparam int BIT_GENOFF = 7;
	localparam logic [7:0] SW_MASK    = 8'hf8;
	localparam logic [7:0] SW_KEEP_AT = 8'h40;

	// configuration bit positions
	localparam int CFG_OSC_USED  = 0;
	localparam int CFG_PMCLK_KEEP = 1;

	// reset values
	localparam logic [7:0] SW_RST    = 8'h00;
	localparam logic [7:0] CFG_RST   = 8'h01;
	localparam logic [7:0] IRQEN_RST = 8'h00;

	// interrupt entry latency in cycles and the counter load that gives it
	localparam int         LAT_CYC = 6;
	localparam logic [2:0] LAT_CNT = 3'(LAT_CYC - 1);

	// byte lane pattern accepted for register writes
	localparam logic [3:0] STRB_BYTE0 = 4'h1;

	// axi responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	// one enable per gated unit
	typedef struct packed {
		logic cpu;
		logic mclk;
		logic pmclk;
		logic sub_main;
		logic dig_osc;
		logic dcgen;
		logic aclk;
	} lpm_clk_t;

	localparam lpm_clk_t CLK_RST = 7'h7f;

	// interrupt sequencer states, gray along idle-entry-serve
	typedef enum logic [1:0] {
		ST_IDLE  = 2'h0,
		ST_ENTRY = 2'h1,
		ST_SERVE = 2'h3
	} lpm_state_t;

endpackage : lpm_pkg

/* design/lpm_ctrl.sv */
// low-power mode controller: status-word mode bits, clock gating, interrupt wake and return
//
// Overview of operation
// (R1) Register area is byte organised; only byte-lane-0 writes are accepted.
// (R2) Sleep levels 0..4 are selected only by the four mode bits.
// (R3) Mode bits are saved with the status word when an interrupt is serviced.
// (R4) Return with unmodified stack copy resumes the earlier mode.
// (R5) Return with modified stack copy enters the mode the modified bits encode.
// (R6) Mode bits and stack copy are freely readable and writable, no unlock.
// (R7) Writing a mode bit switches mode at once.
// (R8) Peripheral on a gated clock stays inactive until that clock runs.
// (R9) Mode changes leave pins, memory and registers untouched.
// (R10) Any enabled interrupt wakes the device from any sleep level.
// (R11) All mode bits zero: CPU runs and every enabled clock is active.
// (R12) Only cpu halt set: CPU and main clock stop; sub-main and auxiliary run.
// (R13) Halt plus loop-off: CPU, main clock, oscillator stop; sub-main and auxiliary run.
// (R14) In that level the DC generator stops only if oscillator sources no clock.
// (R15) Halt plus generator-off: sub-main and oscillator also stop; DC generator stays.
// (R16) Halt, loop-off, generator-off: also DC generator stops; only auxiliary runs.
// (R17) All four bits set: CPU and every clock stop.
// (R18) On wake the program counter and status word are pushed before service.
// (R19) Interrupt entry clears halt, generator-off and oscillator-off bits.
// (R20) Acceptance clears the status word except loop-off, including global enable.
// (R21) Acceptance to first service instruction takes exactly six cycles.
// (R22) Gating enables change only at a safe point given by the clock generator.

`timescale 1ns/1ns
`default_nettype none

module lpm_ctrl #(
	parameter int N_IRQ = 8
) (
	// clock, reset, enable
	input  wire logic                 clk_sys,
	input  wire logic                 rst_n,
	input  wire logic                 ce,
	// axi4-lite write address
	input  wire logic [7:0]           s_axi_awaddr,
	input  wire logic                 s_axi_awvalid,
	output var  logic                 s_axi_awready,
	// axi4-lite write data
	input  wire logic [31:0]          s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	input  wire logic                 s_axi_wvalid,
	output var  logic                 s_axi_wready,
	// axi4-lite write response
	output var  logic [1:0]           s_axi_bresp,
	output var  logic                 s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	// axi4-lite read address
	input  wire logic [7:0]           s_axi_araddr,
	input  wire logic                 s_axi_arvalid,
	output var  logic                 s_axi_arready,
	// axi4-lite read data
	output var  logic [31:0]          s_axi_rdata,
	output var  logic [1:0]           s_axi_rresp,
	output var  logic                 s_axi_rvalid,
	input  wire logic                 s_axi_rready,
	// cpu core side
	input  wire logic                 cpu_sw_we,
	input  wire logic [7:0]           cpu_sw_wdata,
	input  wire logic                 ret_from_irq,
	input  wire logic [N_IRQ-1:0]     irq_req,
	output var  logic [7:0]           status_word,
	output var  logic                 push_strobe,
	output var  logic [7:0]           stack_word,
	output var  logic [N_IRQ-1:0]     irq_ack,
	output var  logic                 isr_start,
	// clock generator side
	input  wire lpm_pkg::lpm_clk_t    gate_safe,
	output var  lpm_pkg::lpm_clk_t    clk_en
);
	import lpm_pkg::*;

	// decode mode bits and config into the wanted unit enables
	function automatic lpm_clk_t mode_decode(input logic [7:0] sw, input logic [7:0] cfg);
		lpm_clk_t e;
		logic     halt;
		logic     lf_off;
		logic     loop_off;
		logic     gen_off;
		halt      = sw[BIT_CPUHLT];
		lf_off    = sw[BIT_LFOFF];
		loop_off  = sw[BIT_LOOPOF];
		gen_off   = sw[BIT_GENOFF];
		e.cpu     = ~halt; // R11 R12
		e.mclk    = ~halt; // R12
		e.pmclk   = ~halt | (cfg[CFG_PMCLK_KEEP] & ~gen_off); // R12
		e.sub_main = ~gen_off; // R13 R15
		e.dig_osc = ~(loop_off | gen_off); // R13 R15 R16
		e.dcgen   = ~(loop_off & (gen_off | ~cfg[CFG_OSC_USED])); // R14 R15 R16
		e.aclk    = ~lf_off; // R16 R17
		return e;
	endfunction : mode_decode

	// highest index pending request wins
	function automatic logic [N_IRQ-1:0] pick_top(input logic [N_IRQ-1:0] req);
		logic [N_IRQ-1:0] one;
		logic             found;
		one   = '0;
		found = 1'b0;
		for (int i = N_IRQ - 1; i >= 0; i--) begin
			if (req[i] && !found) begin
				one[i] = 1'b1;
				found  = 1'b1;
			end
		end
		return one;
	endfunction : pick_top

	logic             rst_meta_n;
	logic             rst_sync_n;
	logic [N_IRQ-1:0] irq_meta;
	logic [N_IRQ-1:0] irq_sync;
	logic [7:0]       cfg;
	logic [N_IRQ-1:0] irq_en;
	lpm_state_t       state;
	logic [2:0]       lat_cnt;
	logic             aw_full;
	logic [7:0]       aw_addr;
	logic             w_full;
	logic [31:0]      w_data;
	logic [3:0]       w_strb;
	logic             accept;
	logic             bus_wr;
	logic             wr_ok;
	lpm_clk_t         want;

	// reset release through two flops; assertion stays asynchronous
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_n <= 1'b0;
			rst_sync_n <= 1'b0;
		end else begin
			rst_meta_n <= 1'b1;
			rst_sync_n <= rst_meta_n;
		end
	end

	// interrupt requests come from other logic, so synchronise them
	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			irq_meta <= '0;
			irq_sync <= '0;
		end else if (ce) begin
			irq_meta <= irq_req;
			irq_sync <= irq_meta;
		end
	end

	// acceptance needs global enable; sleep level does not matter
	assign accept = (state == ST_IDLE) && status_word[BIT_IRQ_ON] && |(irq_sync & irq_en); // R10

	// one word write fires once both address and data are held
	assign bus_wr = aw_full && w_full && !s_axi_bvalid;
	assign wr_ok  = (w_strb == STRB_BYTE0); // R1

	// interrupt sequencer
	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			state     <= ST_IDLE;
			lat_cnt   <= '0;
			isr_start <= 1'b0;
		end else if (ce) begin
			isr_start <= 1'b0;
			unique case (state)
				ST_IDLE: begin
					if (accept) begin
						state   <= ST_ENTRY;
						lat_cnt <= LAT_CNT; // R21
					end
				end
				ST_ENTRY: begin
					if (lat_cnt == 3'h0) begin
						state     <= ST_SERVE;
						isr_start <= 1'b1; // R21
					end else begin
						lat_cnt <= lat_cnt - 3'h1;
					end
				end
				ST_SERVE: begin
					// a single stack copy is kept, so nesting is not offered
					if (ret_from_irq) begin
						state <= ST_IDLE;
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// push strobe and acknowledge of the chosen source
	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			push_strobe <= 1'b0;
			irq_ack     <= '0;
		end else if (ce) begin
			push_strobe <= accept; // R18
			irq_ack     <= accept ? pick_top(irq_sync & irq_en) : '0;
		end
	end

	// live status word: entry beats return beats cpu beats bus
	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			status_word <= SW_RST;
		end else if (ce) begin
			if (accept) begin
				status_word <= status_word & SW_KEEP_AT; // R19 R20
			end else if (state == ST_SERVE && ret_from_irq) begin
				status_word <= stack_word; // R4 R5
			end else if (cpu_sw_we) begin
				status_word <= cpu_sw_wdata & SW_MASK; // R2 R6 R7
			end else if (bus_wr && wr_ok && aw_addr == REG_MODE) begin
				status_word <= w_data[7:0] & SW_MASK; // R6 R7
			end
		end
	end

	// stack copy of the status word
	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			stack_word <= SW_RST;
		end else if (ce) begin
			if (accept) begin
				stack_word <= status_word; // R3 R18
			end else if (bus_wr && wr_ok && aw_addr == REG_STACK) begin
				stack_word <= w_data[7:0] & SW_MASK; // R5 R6
			end
		end
	end

	// configuration and source enables
	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			cfg    <= CFG_RST;
			irq_en <= N_IRQ'(IRQEN_RST);
		end else if (ce && bus_wr && wr_ok) begin
			if (aw_addr == REG_CFG) begin
				cfg <= w_data[7:0];
			end
			if (aw_addr == REG_IRQ_EN) begin
				irq_en <= w_data[N_IRQ-1:0];
			end
		end
	end

	// gating: the wanted level follows the mode bits at once, but each
	// enable only moves when the generator flags that clock as low
	assign want = mode_decode(status_word, cfg);

	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			clk_en <= CLK_RST; // R11
		end else if (ce) begin
			// only enables move here; no pin, memory or register is touched
			clk_en <= lpm_clk_t'((want & gate_safe) | (clk_en & ~gate_safe)); // R7 R8 R9 R22
		end
	end

	// axi write address channel
	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			aw_full       <= 1'b0;
			aw_addr       <= '0;
			s_axi_awready <= 1'b0;
		end else if (ce) begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_full       <= 1'b1;
				aw_addr       <= {s_axi_awaddr[7:2], 2'h0};
				s_axi_awready <= 1'b0;
			end else if (bus_wr) begin
				aw_full <= 1'b0;
			end else begin
				s_axi_awready <= !aw_full && !s_axi_bvalid;
			end
		end
	end

	// axi write data channel
	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			w_full       <= 1'b0;
			w_data       <= '0;
			w_strb       <= '0;
			s_axi_wready <= 1'b0;
		end else if (ce) begin
			if (s_axi_wvalid && s_axi_wready) begin
				w_full       <= 1'b1;
				w_data       <= s_axi_wdata;
				w_strb       <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end else if (bus_wr) begin
				w_full <= 1'b0;
			end else begin
				s_axi_wready <= !w_full && !s_axi_bvalid;
			end
		end
	end

	// axi write response; wide writes are refused so no lane is half-written
	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else if (ce) begin
			if (bus_wr) begin
				s_axi_bvalid <= 1'b1;
				unique case (aw_addr)
					REG_MODE, REG_STACK, REG_CFG, REG_IRQ_EN: begin
						s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR; // R1
					end
					REG_STATUS, REG_PEND: begin
						s_axi_bresp <= RESP_SLVERR;
					end
					default: begin
						s_axi_bresp <= RESP_DECERR;
					end
				endcase
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// axi read channel, one cycle from address to data
	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= RESP_OKAY;
		end else if (ce) begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rresp   <= RESP_OKAY;
				unique case ({s_axi_araddr[7:2], 2'h0})
					REG_MODE: begin
						s_axi_rdata <= {24'h0, status_word}; // R6
					end
					REG_STACK: begin
						s_axi_rdata <= {24'h0, stack_word}; // R6
					end
					REG_CFG: begin
						s_axi_rdata <= {24'h0, cfg};
					end
					REG_IRQ_EN: begin
						s_axi_rdata <= 32'(irq_en);
					end
					REG_STATUS: begin
						s_axi_rdata <= {23'h0, state, clk_en};
					end
					REG_PEND: begin
						s_axi_rdata <= 32'(irq_sync);
					end
					default: begin
						s_axi_rdata <= '0;
						s_axi_rresp <= RESP_DECERR;
					end
				endcase
			end else if (s_axi_rvalid) begin
				if (s_axi_rready) begin
					s_axi_rvalid <= 1'b0;
				end
			end else begin
				s_axi_arready <= 1'b1;
			end
		end
	end

endmodule : lpm_ctrl

`default_nettype wire

/* tb/lpm_cpu_model.sv */
// behavioural cpu core and clock generator facing the mode controller
`timescale 1ns/1ns
`default_nettype none
module lpm_cpu_model #(
	parameter int SVC_CYC = 30
) (
	// clock and reset
	input  wire logic              clk_sys,
	input  wire logic              rst_n,
	// bench control and controller side
	input  wire logic              hold,
	input  wire logic              isr_start,
	output var  logic              ret_from_irq,
	output wire lpm_pkg::lpm_clk_t gate_safe
);
	import lpm_pkg::*;
	int cnt;

	// hold withholds every safe point, a slow clock generator
	assign gate_safe = hold ? lpm_clk_t'(7'h00) : lpm_clk_t'(7'h7f);

	// service routine runs a fixed span, then returns
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cnt          <= 0;
			ret_from_irq <= 1'b0;
		end else begin
			ret_from_irq <= (cnt == 1);
			if (isr_start)
				cnt <= SVC_CYC;
			else if (cnt != 0)
				cnt <= cnt - 1;
		end
	end
endmodule : lpm_cpu_model
`default_nettype wire

/* tb/lpm_ctrl_asserts.sv */
// concurrent checks on the mode controller ports
`timescale 1ns/1ns
`default_nettype none
module lpm_ctrl_asserts #(
	parameter int N_IRQ = 8
) (
	// clock and reset
	input wire logic              clk_sys,
	input wire logic              rst_n,
	// cpu side
	input wire logic              ret_from_irq,
	input wire logic              push_strobe,
	input wire logic              isr_start,
	input wire logic [7:0]        status_word,
	input wire logic [7:0]        stack_word,
	input wire logic [N_IRQ-1:0]  irq_ack,
	// clock generator side
	input wire lpm_pkg::lpm_clk_t gate_safe,
	input wire lpm_pkg::lpm_clk_t clk_en
);
	import lpm_pkg::*;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	// entry walk: five quiet cycles after the push, then service starts
	sequence s_entry_wait;
		!isr_start [*5] ##1 isr_start;
	endsequence
	sequence s_safe_steady(logic safe);
		safe ##1 $stable(status_word);
	endsequence

	property p_lat; push_strobe |=> s_entry_wait; endproperty
	a_lat: assert property (p_lat) else $error("service start latency wrong");
	property p_ack; push_strobe |-> $onehot(irq_ack); endproperty
	a_ack: assert property (p_ack) else $error("ack not one-hot with push");
	property p_clr; push_strobe |-> status_word == ($past(status_word) & SW_KEEP_AT); endproperty
	a_clr: assert property (p_clr) else $error("status not cleared on entry");
	property p_stk; push_strobe |-> stack_word == $past(status_word); endproperty
	a_stk: assert property (p_stk) else $error("stack copy wrong");
	property p_ret; ret_from_irq |=> status_word == $past(stack_word); endproperty
	a_ret: assert property (p_ret) else $error("return did not restore");
	// no safe point means no change, so no clipped pulse
	property p_hold; gate_safe == '0 |=> $stable(clk_en); endproperty
	a_hold: assert property (p_hold) else $error("enable moved off safe point");
	property p_cpu; s_safe_steady(gate_safe.cpu) |-> clk_en.cpu == !status_word[BIT_CPUHLT]; endproperty
	a_cpu: assert property (p_cpu) else $error("cpu enable wrong");
	property p_sm; s_safe_steady(gate_safe.sub_main) |-> clk_en.sub_main == !status_word[BIT_GENOFF]; endproperty
	a_sm: assert property (p_sm) else $error("sub-main enable wrong");
	property p_dco;
		s_safe_steady(gate_safe.dig_osc) |-> clk_en.dig_osc == !(status_word[BIT_LOOPOF] | status_word[BIT_GENOFF]);
	endproperty
	a_dco: assert property (p_dco) else $error("oscillator enable wrong");
	property p_aclk; s_safe_steady(gate_safe.aclk) |-> clk_en.aclk == !status_word[BIT_LFOFF]; endproperty
	a_aclk: assert property (p_aclk) else $error("auxiliary enable wrong");
endmodule : lpm_ctrl_asserts
`default_nettype wire

bind lpm_ctrl lpm_ctrl_asserts #(.N_IRQ(N_IRQ)) i_chk (.clk_sys(clk_sys), .rst_n(rst_n),
	.ret_from_irq(ret_from_irq), .push_strobe(push_strobe), .isr_start(isr_start), .status_word(status_word),
	.stack_word(stack_word), .irq_ack(irq_ack), .gate_safe(gate_safe), .clk_en(clk_en));

/* tb/low_power_mode_control_tb.sv */
// self-checking bench of the low-power mode controller
`timescale 1ns/1ns
`default_nettype none
module low_power_mode_control_tb;
	import lpm_pkg::*;
	logic        clk_sys, rst_n, ce, cpu_sw_we, hold, ret, psh, isr;
	logic        awv, wv, brdy, arv, rrdy, awr, wr, bv, arr, rv;
	logic [1:0]  br, rr;
	logic [3:0]  ws;
	logic [7:0]  aa, ra, swd, sw, stk, irq, ack;
	logic [31:0] wd, rd;
	lpm_clk_t    gs, cen;
	int          fail_count, total_checks, n;

	lpm_ctrl #(.N_IRQ(8)) i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .s_axi_awaddr(aa), .s_axi_awvalid(awv),
		.s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr),
		.s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(brdy), .s_axi_araddr(ra), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rrdy),
		.cpu_sw_we(cpu_sw_we), .cpu_sw_wdata(swd), .ret_from_irq(ret), .irq_req(irq), .status_word(sw),
		.push_strobe(psh), .stack_word(stk), .irq_ack(ack), .isr_start(isr), .gate_safe(gs), .clk_en(cen));
	lpm_cpu_model #(.SVC_CYC(30)) i_cpu (.clk_sys(clk_sys), .rst_n(rst_n), .hold(hold), .isr_start(isr),
		.ret_from_irq(ret), .gate_safe(gs));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic tick(input int k);
		repeat (k) @(posedge clk_sys);
		#1;
	endtask : tick

	// bus write: each channel released once taken
	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
		@(posedge clk_sys);
		aa <= a;
		wd <= d;
		ws <= s;
		awv <= 1'b1;
		wv <= 1'b1;
		brdy <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (awr) awv <= 1'b0;
			if (wr) wv <= 1'b0;
		end while (!bv);
		r = br;
		brdy <= 1'b0;
	endtask : axw

	task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk_sys);
		ra <= a;
		arv <= 1'b1;
		rrdy <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (arr) arv <= 1'b0;
		end while (!rv);
		d = rd;
		r = rr;
		rrdy <= 1'b0;
	endtask : axr

	// cpu instruction writes the status word
	task automatic swr(input logic [7:0] v);
		@(posedge clk_sys);
		cpu_sw_we <= 1'b1;
		swd <= v;
		@(posedge clk_sys);
		cpu_sw_we <= 1'b0;
		tick(3);
	endtask : swr

	task automatic t_regs;
		logic [31:0] d;
		logic [1:0]  r;
		axw(REG_CFG, 32'h0, 4'h3, r);
		chk(r, RESP_SLVERR);
		axr(REG_CFG, d, r);
		chk(d, 32'(CFG_RST));
		axw(REG_STATUS, 32'h0, STRB_BYTE0, r);
		chk(r, RESP_SLVERR);
		axr(8'h20, d, r);
		chk(r, RESP_DECERR);
		axw(REG_IRQ_EN, 32'hfe, STRB_BYTE0, r);
		axr(REG_IRQ_EN, d, r);
		chk(d, 32'hfe);
	endtask : t_regs

	// every level under both oscillator configurations
	task automatic t_modes;
		logic [7:0]  md [6] = '{8'h00, 8'h10, 8'h50, 8'h90, 8'hd0, 8'hf0};
		logic [6:0]  ex [12] = '{7'h7f, 7'h0f, 7'h0b, 7'h03, 7'h01, 7'h00, 7'h7f, 7'h1f, 7'h19, 7'h03, 7'h01, 7'h00};
		logic [31:0] d;
		logic [1:0]  r;
		for (int c = 0; c < 2; c++) begin
			axw(REG_CFG, c ? 32'h2 : 32'h1, STRB_BYTE0, r);
			for (int i = 0; i < 6; i++) begin
				swr(md[i]);
				chk(cen, ex[c * 6 + i]);
			end
		end
		axw(REG_MODE, 32'h90, STRB_BYTE0, r);
		tick(3);
		chk(cen, 7'h03);
		axr(REG_MODE, d, r);
		chk(d, 32'h90);
		axr(REG_STATUS, d, r);
		chk(d, 32'h3);
		@(posedge clk_sys);
		hold <= 1'b1;
		swr(8'h10);
		tick(4);
		chk(cen, 7'h03);
		@(posedge clk_sys);
		hold <= 1'b0;
		tick(3);
		chk(cen, 7'h1f);
	endtask : t_modes

	// wake from a level, optionally patching the saved copy
	task automatic t_irq(input logic [7:0] m, input logic [7:0] nst, input logic mod);
		logic [1:0] r;
		swr(m);
		@(posedge clk_sys);
		irq <= 8'h24;
		for (n = 0; n < 40 && psh !== 1'b1; n++) tick(1);
		chk(ack, 8'h20);
		chk(sw, m & SW_KEEP_AT);
		chk(stk, m);
		for (n = 0; n < 10 && isr !== 1'b1; n++) begin
			@(posedge clk_sys);
			irq <= 8'h00;
			#1;
		end
		chk(n, LAT_CYC);
		if (mod) axw(REG_STACK, {24'h0, nst}, STRB_BYTE0, r);
		for (n = 0; n < 60 && ret !== 1'b1; n++) tick(1);
		tick(1);
		chk(sw, mod ? nst : m);
	endtask : t_irq

	// masked source must not wake
	task automatic t_mask;
		swr(8'h18);
		@(posedge clk_sys);
		irq <= 8'h01;
		tick(10);
		chk(sw, 8'h18);
		@(posedge clk_sys);
		irq <= 8'h00;
	endtask : t_mask

	// enable low freezes the status word against a cpu write
	task automatic t_ce;
		@(posedge clk_sys);
		ce <= 1'b0;
		swr(8'h90);
		chk(sw, 8'h18);
		@(posedge clk_sys);
		ce <= 1'b1;
		tick(2);
	endtask : t_ce

	task automatic end_sim;
		if (fail_count == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : end_sim

	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	// main sequence
	initial begin
		rst_n = 1'b0;
		{awv, wv, brdy, arv, rrdy, cpu_sw_we, hold} = '0;
		ce = 1'b1;
		{aa, ra, swd, irq, ws, wd} = '0;
		repeat (10) @(posedge clk_sys);
		rst_n <= 1'b1;
		tick(4);
		t_regs;
		t_modes;
		t_irq(8'hd8, 8'h00, 1'b0);
		t_irq(8'hf8, 8'h08, 1'b1);
		t_irq(8'h18, 8'h58, 1'b1);
		t_mask;
		t_ce;
		end_sim;
	end

	// watchdog well beyond the expected run
	initial begin
		#200000;
		fail_count++;
		end_sim;
	end
endmodule : low_power_mode_control_tb
`default_nettype wire
